// ==== hw/pcb_defs.svh ====
// Purpose: Register offsets, fields, reset values and masks
// Assumes: 5-bit register index, 16-bit register data
// Notes:   Definitions only
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCB_ADDR_W        5
`define PCB_DATA_W        16
`define PCB_OFS_CFG       5'h14
`define PCB_OFS_ERRCNT    5'h15
`define PCB_OFS_TEST      5'h16
`define PCB_OFS_STATUS    5'h17

// ----------------------------------------------------------------
// general_config_two fields
// ----------------------------------------------------------------
`define PCB_CFG_RST       16'h2947
`define PCB_CFG_MASK      16'haf7f
`define PCB_CFG_PD        15
`define PCB_CFG_INTPOL    13
`define PCB_CFG_TRY_HI    11
`define PCB_CFG_TRY_LO    10
`define PCB_CFG_DS_EN     9
`define PCB_CFG_ENERGY    8
`define PCB_CFG_TEN       6
`define PCB_CFG_CLK_HI    5
`define PCB_CFG_CLK_LO    4
`define PCB_CFG_COLFD     3
`define PCB_CFG_OLDSCR    2
`define PCB_CFG_SEMI_M    1
`define PCB_CFG_SEMI_S    0

// ----------------------------------------------------------------
// self_test_control fields
// ----------------------------------------------------------------
`define PCB_TEST_RST      16'h0000
`define PCB_TEST_MASK     16'hf0ff
`define PCB_TEST_GEN_HI   15
`define PCB_TEST_GEN_LO   12
`define PCB_TEST_FWD      7
`define PCB_TEST_TXLINE   6
`define PCB_TEST_LP_HI    5
`define PCB_TEST_LP_LO    2
`define PCB_TEST_PCS_HI   1
`define PCB_TEST_PCS_LO   0
`define PCB_GEN_OFF       4'h0
`define PCB_GEN_RUN       4'hf
`define PCB_LP_CODE_NONE  4'h0
`define PCB_LP_CODE_DIG   4'h1
`define PCB_LP_CODE_ANA   4'h2
`define PCB_LP_CODE_EXT   4'h4
`define PCB_LP_CODE_REV   4'h8
`define PCB_PCS_CODE_OFF  2'h0
`define PCB_PCS_CODE_PRE  2'h1
`define PCB_PCS_CODE_MID  2'h2
`define PCB_PCS_CODE_POST 2'h3

// ----------------------------------------------------------------
// general_status_two fields
// ----------------------------------------------------------------
`define PCB_STAT_RST      16'h0040
`define PCB_STAT_LOCK     11
`define PCB_STAT_BUSY     9
`define PCB_STAT_SCR_M    8
`define PCB_STAT_SCR_S    7
`define PCB_STAT_PWR      6

// ----------------------------------------------------------------
// Downshift try limits per code
// ----------------------------------------------------------------
`define PCB_TRY_0         4'h1
`define PCB_TRY_1         4'h2
`define PCB_TRY_2         4'h4
`define PCB_TRY_3         4'h8

`endif

// ==== hw/pcb_pkg.sv ====
// Purpose: Types for the two ends of the management link, each type used by one end
// Assumes: Nothing
// Notes:   Numbers live in pcb_defs.svh
package pcb_pkg;

  typedef enum logic [1:0] {
    PCB_CLK_2M5,
    PCB_CLK_25M,
    PCB_CLK_OFF
  } pcb_txclk_e;

  typedef enum logic [2:0] {
    PCB_LP_NONE,
    PCB_LP_DIGITAL,
    PCB_LP_ANALOG,
    PCB_LP_EXTERNAL,
    PCB_LP_REVERSE
  } pcb_loop_e;

  typedef enum logic [2:0] {
    PCB_PCS_OFF,
    PCB_PCS_PRE_SCR,
    PCB_PCS_POST_SCR,
    PCB_PCS_POST_ENC,
    PCB_PCS_PRE_GIG
  } pcb_pcs_e;

  typedef enum logic {
    PCB_H_IDLE,
    PCB_H_WAIT
  } pcb_hstate_e;

endpackage

// ==== hw/pcb_mgmt_if.sv ====
// Purpose: Management register link between controller and PHY logic
// Assumes: One clock shared by both ends
// Notes:   Request is a one-cycle strobe, answer one cycle later
`timescale 1ns/1ns
`include "pcb_defs.svh"

interface pcb_mgmt_if;
  logic                     mgmtReq;
  logic                     mgmtWrite;
  logic [`PCB_ADDR_W-1:0]   mgmtAddr;
  logic [`PCB_DATA_W-1:0]   mgmtWdata;
  logic                     mgmtAck;
  logic [`PCB_DATA_W-1:0]   mgmtRdata;

  modport dev (
    input  mgmtReq,
    input  mgmtWrite,
    input  mgmtAddr,
    input  mgmtWdata,
    output mgmtAck,
    output mgmtRdata
  );

  modport host (
    output mgmtReq,
    output mgmtWrite,
    output mgmtAddr,
    output mgmtWdata,
    input  mgmtAck,
    input  mgmtRdata
  );
endinterface

// ==== hw/pcb_downshift.sv ====
// Purpose: Speed fallback after failed link attempts
// Assumes: Attempt-fail inputs are one-cycle pulses
// Notes:   Fallback holds until linkUp or the enable drops
`timescale 1ns/1ns
`include "pcb_defs.svh"

module pcb_downshift
  import pcb_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       dsEnable,
  input  wire logic [1:0] tryLimitCode,
  input  wire logic       energyCheckEn,
  input  wire logic       tenEnable,
  input  wire logic       gigAttemptFail,
  input  wire logic       fastAttemptFail,
  input  wire logic       noEnergyCD,
  input  wire logic       linkUp,
  output logic            dropToFast,
  output logic            dropToTen
);

  generate
    if (CNT_W < 4) begin : g_chk
      $error("pcb_downshift: CNT_W must be at least 4");
    end
  endgenerate

  logic [CNT_W-1:0] failCnt_ff;
  logic [CNT_W-1:0] limit;
  logic             fastFf;
  logic             tenFf;
  logic             hitLimit;

  always_comb begin
    case (tryLimitCode)
      2'h0:    limit = CNT_W'(`PCB_TRY_0);
      2'h1:    limit = CNT_W'(`PCB_TRY_1);
      2'h2:    limit = CNT_W'(`PCB_TRY_2);
      default: limit = CNT_W'(`PCB_TRY_3);
    endcase
  end

  assign hitLimit = gigAttemptFail && (failCnt_ff + 1'b1 >= limit);

  // ----------------------------------------------------------------
  // Failed gigabit attempt count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn || linkUp || !dsEnable) begin
      failCnt_ff <= '0;
    end else if (gigAttemptFail && !hitLimit) begin
      failCnt_ff <= failCnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fallback levels
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn || linkUp || !dsEnable) begin
      fastFf <= 1'b0;
      tenFf  <= 1'b0;
    end else begin
      if (hitLimit) begin
        fastFf <= 1'b1;
      end
      if (gigAttemptFail && energyCheckEn && noEnergyCD) begin
        fastFf <= 1'b1;
      end
      if (fastFf && fastAttemptFail && tenEnable) begin
        tenFf <= 1'b1;
      end
    end
  end

  assign dropToFast = fastFf;
  assign dropToTen  = tenFf;

endmodule

// ==== hw/pcb_dev_end.sv ====
// Purpose: PHY configuration, error counter and self-test registers
// Assumes: Management requests are one-cycle strobes on ref_clk
// Notes:   Tags below
`timescale 1ns/1ns
`include "pcb_defs.svh"

module pcb_dev_end
  import pcb_pkg::*;
#(
  parameter int ERR_W = 16
) (
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  pcb_mgmt_if.dev     mgmt,
  input  wire logic   pdDone,
  input  wire logic   rxError,
  input  wire logic   intRaw,
  input  wire logic   colRaw,
  input  wire logic   fullDuplex,
  input  wire logic   speedGig,
  input  wire logic   speedFast,
  input  wire logic   gigMaster,
  input  wire logic   gigSlave,
  input  wire logic   gigAttemptFail,
  input  wire logic   fastAttemptFail,
  input  wire logic   noEnergyCD,
  input  wire logic   linkUp,
  input  wire logic   checkerLocked,
  input  wire logic   generatorRunning,
  input  wire logic   legacyMasterActive,
  input  wire logic   legacySlaveActive,
  input  wire logic   corePowerNormal,
  output logic        pdProbeEnable,
  output logic        intPin,
  output pcb_txclk_e  txClkRate,
  output logic        colOut,
  output logic        oldScramblerSel,
  output logic        semiCrossEn,
  output logic        dropToFast,
  output logic        dropToTen,
  output logic        generatorOn,
  output pcb_loop_e   loopPoint,
  output pcb_pcs_e    pcsLoop,
  output logic        forwardRxToMac,
  output logic        loopTxToLine
);

  generate
    if (ERR_W != `PCB_DATA_W) begin : g_chk
      $error("pcb_dev_end: ERR_W must equal the register width");
    end
  endgenerate

  logic [15:0] cfg_ff;
  logic [15:0] test_ff;
  logic [15:0] errCnt_ff;
  logic [15:0] nxt_errCnt;
  logic [15:0] status;
  logic        ack_ff;
  logic [15:0] rdata_ff;
  logic        wrCfg;
  logic        wrErr;
  logic        wrTest;
  pcb_loop_e   nxt_loopPoint;
  pcb_pcs_e    nxt_pcsLoop;
  pcb_txclk_e  nxt_txClk;

  assign wrCfg  = mgmt.mgmtReq && mgmt.mgmtWrite
                  && mgmt.mgmtAddr == `PCB_OFS_CFG;
  assign wrErr  = mgmt.mgmtReq && mgmt.mgmtWrite
                  && mgmt.mgmtAddr == `PCB_OFS_ERRCNT;
  assign wrTest = mgmt.mgmtReq && mgmt.mgmtWrite
                  && mgmt.mgmtAddr == `PCB_OFS_TEST;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_ff <= `PCB_CFG_RST;
    end else if (wrCfg) begin
      cfg_ff <= mgmt.mgmtWdata & `PCB_CFG_MASK;
    end else if (pdDone) begin
      cfg_ff[`PCB_CFG_PD] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Self-test control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      test_ff <= `PCB_TEST_RST;
    end else if (wrTest) begin
      test_ff <= mgmt.mgmtWdata & `PCB_TEST_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Receive error counter, a new error survives a clear
  // ----------------------------------------------------------------
  always_comb begin
    nxt_errCnt = errCnt_ff;
    if (wrErr) begin
      nxt_errCnt = errCnt_ff & ~mgmt.mgmtWdata;
    end
    if (rxError && nxt_errCnt != 16'hffff) begin
      nxt_errCnt = nxt_errCnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      errCnt_ff <= 16'h0000;
    end else begin
      errCnt_ff <= nxt_errCnt;
    end
  end

  // ----------------------------------------------------------------
  // Status and read path
  // ----------------------------------------------------------------
  always_comb begin
    status = 16'h0000;
    status[`PCB_STAT_LOCK]  = checkerLocked;
    status[`PCB_STAT_BUSY]  = generatorRunning;
    status[`PCB_STAT_SCR_M] = legacyMasterActive;
    status[`PCB_STAT_SCR_S] = legacySlaveActive;
    status[`PCB_STAT_PWR]   = corePowerNormal;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ack_ff <= mgmt.mgmtReq;
      if (mgmt.mgmtReq) begin
        case (mgmt.mgmtAddr)
          `PCB_OFS_CFG:    rdata_ff <= cfg_ff;
          `PCB_OFS_ERRCNT: rdata_ff <= errCnt_ff;
          `PCB_OFS_TEST:   rdata_ff <= test_ff;
          `PCB_OFS_STATUS: rdata_ff <= status;
          default:         rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  assign mgmt.mgmtAck   = ack_ff;
  assign mgmt.mgmtRdata = rdata_ff;

  // ----------------------------------------------------------------
  // Loop and clock decode
  // ----------------------------------------------------------------
  always_comb begin
    case (test_ff[`PCB_TEST_LP_HI:`PCB_TEST_LP_LO])
      `PCB_LP_CODE_DIG: nxt_loopPoint = PCB_LP_DIGITAL;
      `PCB_LP_CODE_ANA: nxt_loopPoint = PCB_LP_ANALOG;
      `PCB_LP_CODE_EXT: nxt_loopPoint = PCB_LP_EXTERNAL;
      `PCB_LP_CODE_REV: nxt_loopPoint = PCB_LP_REVERSE;
      default:          nxt_loopPoint = PCB_LP_NONE;
    endcase
    nxt_pcsLoop = PCB_PCS_OFF;
    if (speedGig && test_ff[`PCB_TEST_PCS_LO]) begin
      nxt_pcsLoop = PCB_PCS_PRE_GIG;
    end else if (speedFast) begin
      case (test_ff[`PCB_TEST_PCS_HI:`PCB_TEST_PCS_LO])
        `PCB_PCS_CODE_PRE:  nxt_pcsLoop = PCB_PCS_PRE_SCR;
        `PCB_PCS_CODE_MID:  nxt_pcsLoop = PCB_PCS_POST_SCR;
        `PCB_PCS_CODE_POST: nxt_pcsLoop = PCB_PCS_POST_ENC;
        default:            nxt_pcsLoop = PCB_PCS_OFF;
      endcase
    end
    case (cfg_ff[`PCB_CFG_CLK_HI:`PCB_CFG_CLK_LO])
      2'h0:    nxt_txClk = PCB_CLK_2M5;
      2'h1:    nxt_txClk = PCB_CLK_25M;
      default: nxt_txClk = PCB_CLK_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered datapath controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      intPin          <= 1'b1;
      txClkRate       <= PCB_CLK_2M5;
      colOut          <= 1'b0;
      oldScramblerSel <= 1'b0;
      semiCrossEn     <= 1'b0;
      generatorOn     <= 1'b0;
      loopPoint       <= PCB_LP_NONE;
      pcsLoop         <= PCB_PCS_OFF;
      forwardRxToMac  <= 1'b0;
      loopTxToLine    <= 1'b0;
    end else begin
      intPin    <= intRaw ^ cfg_ff[`PCB_CFG_INTPOL];
      txClkRate <= speedGig ? nxt_txClk : PCB_CLK_OFF;
      colOut    <= colRaw
                   && (!fullDuplex || cfg_ff[`PCB_CFG_COLFD]);
      oldScramblerSel <= speedGig && gigMaster
                         && cfg_ff[`PCB_CFG_OLDSCR];
      semiCrossEn <= speedGig
                     && ((gigMaster && cfg_ff[`PCB_CFG_SEMI_M])
                     || (gigSlave && cfg_ff[`PCB_CFG_SEMI_S]));
      generatorOn <= test_ff[`PCB_TEST_GEN_HI:`PCB_TEST_GEN_LO]
                     == `PCB_GEN_RUN;
      loopPoint <= (nxt_pcsLoop == PCB_PCS_OFF) ? nxt_loopPoint
                   : PCB_LP_NONE;
      pcsLoop   <= nxt_pcsLoop;
      forwardRxToMac <= nxt_loopPoint == PCB_LP_REVERSE
                        && test_ff[`PCB_TEST_FWD];
      loopTxToLine <= nxt_loopPoint == PCB_LP_DIGITAL
                      && test_ff[`PCB_TEST_TXLINE];
    end
  end

  assign pdProbeEnable = cfg_ff[`PCB_CFG_PD];

  // ----------------------------------------------------------------
  // Speed fallback
  // ----------------------------------------------------------------
  pcb_downshift #(
    .CNT_W (4)
  ) u_downshift (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .dsEnable        (cfg_ff[`PCB_CFG_DS_EN]),
    .tryLimitCode    (cfg_ff[`PCB_CFG_TRY_HI:`PCB_CFG_TRY_LO]),
    .energyCheckEn   (cfg_ff[`PCB_CFG_ENERGY]),
    .tenEnable       (cfg_ff[`PCB_CFG_TEN]),
    .gigAttemptFail  (gigAttemptFail),
    .fastAttemptFail (fastAttemptFail),
    .noEnergyCD      (noEnergyCD),
    .linkUp          (linkUp),
    .dropToFast      (dropToFast),
    .dropToTen       (dropToTen)
  );

endmodule

// ==== hw/pcb_host_end.sv ====
// Purpose: Station management side issuing register accesses
// Assumes: One command outstanding at a time
// Notes:   Self-test writes are cleaned of illegal combinations
`timescale 1ns/1ns
`include "pcb_defs.svh"

module pcb_host_end
  import pcb_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  pcb_mgmt_if.host                    mgmt,
  input  wire logic                   cmdValid,
  input  wire logic                   cmdWrite,
  input  wire logic [`PCB_ADDR_W-1:0] cmdAddr,
  input  wire logic [`PCB_DATA_W-1:0] cmdWdata,
  output logic                        cmdReady,
  output logic                        rspValid,
  output logic [`PCB_DATA_W-1:0]      rspData
);

  pcb_hstate_e      state_ff;
  logic             req_ff;
  logic             write_ff;
  logic [4:0]       addr_ff;
  logic [15:0]      wdata_ff;
  logic [15:0]      clean;
  logic [3:0]       lpCode;

  // ----------------------------------------------------------------
  // Self-test write cleanup
  // ----------------------------------------------------------------
  always_comb begin
    clean  = cmdWdata;
    lpCode = cmdWdata[`PCB_TEST_LP_HI:`PCB_TEST_LP_LO];
    if (cmdWdata[`PCB_TEST_GEN_HI:`PCB_TEST_GEN_LO] != `PCB_GEN_RUN) begin
      clean[`PCB_TEST_GEN_HI:`PCB_TEST_GEN_LO] = `PCB_GEN_OFF;
    end
    if (lpCode != `PCB_LP_CODE_REV) begin
      clean[`PCB_TEST_FWD] = 1'b0;
    end
    if (lpCode != `PCB_LP_CODE_DIG) begin
      clean[`PCB_TEST_TXLINE] = 1'b0;
    end
    if (lpCode != `PCB_LP_CODE_NONE) begin
      clean[`PCB_TEST_PCS_HI:`PCB_TEST_PCS_LO] = `PCB_PCS_CODE_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= PCB_H_IDLE;
      req_ff   <= 1'b0;
      write_ff <= 1'b0;
      addr_ff  <= 5'h00;
      wdata_ff <= 16'h0000;
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
    end else begin
      req_ff   <= 1'b0;
      rspValid <= 1'b0;
      case (state_ff)
        PCB_H_IDLE: begin
          if (cmdValid) begin
            req_ff   <= 1'b1;
            write_ff <= cmdWrite;
            addr_ff  <= cmdAddr;
            wdata_ff <= (cmdAddr == `PCB_OFS_TEST) ? clean : cmdWdata;
            state_ff <= PCB_H_WAIT;
          end
        end
        PCB_H_WAIT: begin
          if (mgmt.mgmtAck) begin
            rspValid <= 1'b1;
            rspData  <= mgmt.mgmtRdata;
            state_ff <= PCB_H_IDLE;
          end
        end
        default: state_ff <= PCB_H_IDLE;
      endcase
    end
  end

  assign cmdReady       = state_ff == PCB_H_IDLE;
  assign mgmt.mgmtReq   = req_ff;
  assign mgmt.mgmtWrite = write_ff;
  assign mgmt.mgmtAddr  = addr_ff;
  assign mgmt.mgmtWdata = wdata_ff;

endmodule

// ==== verification/pcb_mgmt_sva.sv ====
// Purpose: Timing and read-value checks on the management link
// Assumes: One clock, synchronous active-low reset
// Notes:   Instantiated beside the interface, no bind
`timescale 1ns/1ns
`include "pcb_defs.svh"

module pcb_mgmt_sva (
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  input wire logic                   mgmtReq,
  input wire logic                   mgmtWrite,
  input wire logic [`PCB_ADDR_W-1:0] mgmtAddr,
  input wire logic [`PCB_DATA_W-1:0] mgmtWdata,
  input wire logic                   mgmtAck,
  input wire logic [`PCB_DATA_W-1:0] mgmtRdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Link handshake
  // ----------------------------------------------------------------
  ack_follows_req_a: assert property (mgmtReq |=> mgmtAck)
    else $error("no answer after request");
  ack_needs_req_a: assert property (!mgmtReq |=> !mgmtAck)
    else $error("answer without request");
  req_spacing_a: assert property (mgmtReq |=> !mgmtReq [*2])
    else $error("requests too close");
  rdata_holds_a: assert property ($changed(mgmtRdata) |-> mgmtAck)
    else $error("read data moved outside answer cycle");

  // ----------------------------------------------------------------
  // Read values
  // ----------------------------------------------------------------
  cfg_resv_zero_a: assert property (mgmtAck && !$past(mgmtWrite) &&
    $past(mgmtAddr) == `PCB_OFS_CFG |-> (mgmtRdata & 16'h5080) == 16'h0)
    else $error("config reserved bits not zero");
  test_resv_zero_a: assert property (mgmtAck && !$past(mgmtWrite) &&
    $past(mgmtAddr) == `PCB_OFS_TEST |-> (mgmtRdata & 16'h0f00) == 16'h0)
    else $error("self-test reserved bits not zero");
  stat_resv_zero_a: assert property (mgmtAck && !$past(mgmtWrite) &&
    $past(mgmtAddr) == `PCB_OFS_STATUS |-> (mgmtRdata & 16'hf43f) == 16'h0)
    else $error("status reserved bits not zero");
  unmapped_zero_a: assert property (mgmtAck && !$past(mgmtWrite) &&
    ($past(mgmtAddr) < 5'h14 || $past(mgmtAddr) > 5'h17) |->
    mgmtRdata == 16'h0)
    else $error("unmapped index read not zero");
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Both ends joined, checked against a bench model
// Assumes: 20 MHz ref_clk, synchronous active-low reset
// Notes:   Inputs driven at rising edges
`timescale 1ns/1ns
`include "pcb_defs.svh"

module tb_top
  import pcb_pkg::*;
;
  logic        ref_clk = 1'b0, resetn = 1'b0;
  logic        cmdValid = 1'b0, cmdWrite = 1'b0, cmdReady, rspValid;
  logic [4:0]  cmdAddr = 5'h00;
  logic [15:0] cmdWdata = 16'h0000, rspData, rd, d, t, cfgM, errM;
  logic        pdDone = 1'b0, rxError = 1'b0, intRaw = 1'b0, colRaw = 1'b0;
  logic        fullDuplex = 1'b0, speedGig = 1'b0, speedFast = 1'b1;
  logic        gigMaster = 1'b0, gigSlave = 1'b0, gigAttemptFail = 1'b0;
  logic        fastAttemptFail = 1'b0, noEnergyCD = 1'b0, linkUp = 1'b0;
  logic        checkerLocked = 1'b0, generatorRunning = 1'b0;
  logic        legacyMasterActive = 1'b0, legacySlaveActive = 1'b0;
  logic        corePowerNormal = 1'b1, pdProbeEnable, intPin, colOut;
  logic        oldScramblerSel, semiCrossEn, dropToFast, dropToTen;
  logic        generatorOn, forwardRxToMac, loopTxToLine;
  pcb_txclk_e  txClkRate;
  pcb_loop_e   loopPoint;
  pcb_pcs_e    pcsLoop;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [31:0] rng = 32'hade6;
  logic [15:0] testTab[$] = '{16'hf0c1, 16'hf0c5, 16'hf0c9, 16'hf0d1,
    16'hf0e1, 16'hf0cd, 16'h50c6, 16'h0002, 16'h0003, 16'hfff3};

  pcb_mgmt_if pcb_mgmt_if_inst ();
  pcb_host_end pcb_host_end_inst (.ref_clk, .resetn,
    .mgmt(pcb_mgmt_if_inst), .cmdValid, .cmdWrite, .cmdAddr, .cmdWdata,
    .cmdReady, .rspValid, .rspData);
  pcb_dev_end pcb_dev_end_inst (.ref_clk, .resetn,
    .mgmt(pcb_mgmt_if_inst), .pdDone, .rxError, .intRaw, .colRaw,
    .fullDuplex, .speedGig, .speedFast, .gigMaster, .gigSlave,
    .gigAttemptFail, .fastAttemptFail, .noEnergyCD, .linkUp,
    .checkerLocked, .generatorRunning, .legacyMasterActive,
    .legacySlaveActive, .corePowerNormal, .pdProbeEnable, .intPin,
    .txClkRate, .colOut, .oldScramblerSel, .semiCrossEn, .dropToFast,
    .dropToTen, .generatorOn, .loopPoint, .pcsLoop, .forwardRxToMac,
    .loopTxToLine);
  pcb_mgmt_sva pcb_mgmt_sva_inst (.ref_clk, .resetn,
    .mgmtReq(pcb_mgmt_if_inst.mgmtReq),
    .mgmtWrite(pcb_mgmt_if_inst.mgmtWrite),
    .mgmtAddr(pcb_mgmt_if_inst.mgmtAddr),
    .mgmtWdata(pcb_mgmt_if_inst.mgmtWdata),
    .mgmtAck(pcb_mgmt_if_inst.mgmtAck),
    .mgmtRdata(pcb_mgmt_if_inst.mgmtRdata));

  always #25 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Host command, ends in the response cycle
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [15:0] wd);
    int n = 1;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdAddr <= a;
    cmdWdata <= wd;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    @(negedge ref_clk);
    while (rspValid !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk("rspLatency", 16'(n), 16'h3);
    chk("cmdReady", cmdReady, 1'b1);
    rd = rspData;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a,
                       input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(nm, rd, exp);
  endtask

  task automatic failPulse(input logic fast);
    @(posedge ref_clk);
    gigAttemptFail <= ~fast;
    fastAttemptFail <= fast;
    @(posedge ref_clk);
    gigAttemptFail <= 1'b0;
    fastAttemptFail <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pulseLink();
    @(posedge ref_clk);
    linkUp <= 1'b1;
    @(posedge ref_clk);
    linkUp <= 1'b0;
    @(negedge ref_clk);
  endtask

  // Host cleanup of self-test writes
  function automatic logic [15:0] clean(input logic [15:0] w);
    logic [3:0] lp;
    lp = w[5:2];
    if (w[15:12] != 4'hf) w[15:12] = 4'h0;
    if (lp != 4'h8) w[7] = 1'b0;
    if (lp != 4'h1) w[6] = 1'b0;
    if (lp != 4'h0) w[1:0] = 2'h0;
    return w & 16'hf0ff;
  endfunction

  function automatic pcb_loop_e expLp(input logic [3:0] lp);
    case (lp)
      4'h1: return PCB_LP_DIGITAL;
      4'h2: return PCB_LP_ANALOG;
      4'h4: return PCB_LP_EXTERNAL;
      4'h8: return PCB_LP_REVERSE;
      default: return PCB_LP_NONE;
    endcase
  endfunction

  function automatic pcb_pcs_e expPcs(input logic [1:0] c, input logic g);
    if (c == 2'h0) return PCB_PCS_OFF;
    if (g) return c[0] ? PCB_PCS_PRE_GIG : PCB_PCS_OFF;
    return c == 2'h1 ? PCB_PCS_PRE_SCR :
           (c == 2'h2 ? PCB_PCS_POST_SCR : PCB_PCS_POST_ENC);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk("cfgReset", `PCB_OFS_CFG, 16'h2947);
    rdchk("errReset", `PCB_OFS_ERRCNT, 16'h0000);
    rdchk("testReset", `PCB_OFS_TEST, 16'h0000);
    rdchk("statReset", `PCB_OFS_STATUS, 16'h0040);
    rdchk("unmapped", 5'h1f, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      t = rnd();
      @(posedge ref_clk);
      {intRaw, colRaw, fullDuplex, gigMaster, gigSlave} <= t[4:0];
      {checkerLocked, generatorRunning, legacyMasterActive} <= t[7:5];
      {legacySlaveActive, corePowerNormal, speedGig} <= t[10:8];
      speedFast <= ~t[8];
      acc(1'b1, `PCB_OFS_CFG, d);
      cfgM = d & `PCB_CFG_MASK;
      rdchk("cfg", `PCB_OFS_CFG, cfgM);
      chk("pdProbe", pdProbeEnable, cfgM[15]);
      chk("intPin", intPin, intRaw ^ cfgM[13]);
      chk("txClk", txClkRate, (!speedGig || cfgM[5]) ? PCB_CLK_OFF :
        (cfgM[4] ? PCB_CLK_25M : PCB_CLK_2M5));
      chk("col", colOut, colRaw & (~fullDuplex | cfgM[3]));
      chk("oldScr", oldScramblerSel, speedGig & gigMaster & cfgM[2]);
      chk("semi", semiCrossEn,
        speedGig & (gigMaster & cfgM[1] | gigSlave & cfgM[0]));
      rdchk("status", `PCB_OFS_STATUS, {4'h0, checkerLocked,
        1'b0, generatorRunning, legacyMasterActive, legacySlaveActive,
        corePowerNormal, 6'h00});
    end
    acc(1'b1, `PCB_OFS_CFG, 16'h8947);
    @(posedge ref_clk);
    pdDone <= 1'b1;
    noEnergyCD <= 1'b1;
    @(posedge ref_clk);
    pdDone <= 1'b0;
    rdchk("pdDone", `PCB_OFS_CFG, 16'h0947);
    $display("config done");
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      acc(1'b1, `PCB_OFS_ERRCNT, 16'hffff);
      errM = {11'h000, d[4:0]} + 16'h0001;
      @(posedge ref_clk);
      rxError <= 1'b1;
      repeat (errM) @(posedge ref_clk);
      rxError <= 1'b0;
      rdchk("errCount", `PCB_OFS_ERRCNT, errM);
      d = rnd();
      acc(1'b1, `PCB_OFS_ERRCNT, d);
      rdchk("errClear", `PCB_OFS_ERRCNT, errM & ~d);
    end
    $display("error counter done");
    for (int p = 0; p < 20; p++) begin
      @(posedge ref_clk);
      speedGig <= p[0];
      speedFast <= ~p[0];
      acc(1'b1, `PCB_OFS_TEST, testTab[p / 2]);
      t = clean(testTab[p / 2]);
      rdchk("test", `PCB_OFS_TEST, t);
      chk("genOn", generatorOn, t[15:12] == 4'hf);
      chk("loopPt", loopPoint, expLp(t[5:2]));
      chk("pcsLoop", pcsLoop, expPcs(t[1:0], speedGig));
      chk("fwdRx", forwardRxToMac, t[5:2] == 4'h8 && t[7]);
      chk("txLine", loopTxToLine, t[5:2] == 4'h1 && t[6]);
    end
    $display("self-test done");
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, `PCB_OFS_CFG, 16'h0200 | 16'(c << 10));
      pulseLink();
      repeat ((1 << c) - 1) failPulse(1'b0);
      chk("noDrop", dropToFast, 1'b0);
      failPulse(1'b0);
      chk("drop", dropToFast, 1'b1);
    end
    acc(1'b1, `PCB_OFS_CFG, 16'h0f00);
    pulseLink();
    failPulse(1'b0);
    chk("energyDrop", dropToFast, 1'b1);
    acc(1'b1, `PCB_OFS_CFG, 16'h0f40);
    failPulse(1'b1);
    chk("tenDrop", dropToTen, 1'b1);
    acc(1'b1, `PCB_OFS_CFG, 16'h0140);
    @(negedge ref_clk);
    chk("offFast", dropToFast, 1'b0);
    chk("offTen", dropToTen, 1'b0);
    $display("downshift done");
    end_of_test();
  end
endmodule
